//--- design/tfe_exc_unit.sv
/*
  Trace and format-error exception unit: arms traces, orders them against faults,
  forced exceptions and interrupts, runs frame checks and presents exception entries.
  Assumes core handshakes are synchronous to ref_clk_i; only the coprocessor error and the reset release are synchronised.
*/
// The Avalon-MM slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
module tfe_exc_unit
  import tfe_pkg::*;
#(
  parameter logic [3:0] CPU_VERSION = 4'h1  // arbitrary value
)
(
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic             irq_o,
  input  wire logic        instr_start_i,
  input  wire tfe_cls_t    instr_class_i,
  input  wire logic [15:0] status_word_i,
  input  wire logic        instr_done_i,
  input  wire logic [15:0] done_status_i,
  input  wire logic [31:0] next_pc_i,
  input  wire logic        instr_fault_i,
  input  wire logic        forced_exc_i,
  input  wire logic        forced_ret_i,
  output logic             stop_inhibit_o,
  output logic             irq_hold_o,
  input  wire logic        rte_check_i,
  input  wire logic [3:0]  rte_frame_fmt_i,
  input  wire logic [3:0]  rte_frame_ver_i,
  input  wire logic [31:0] stack_ptr_i,
  output logic      [31:0] ver_addr_o,
  input  wire logic        mod_check_i,
  input  wire logic [2:0]  mod_opt_i,
  input  wire logic [4:0]  mod_type_i,
  input  wire logic        mmu_rights_err_i,
  input  wire logic [31:0] chk_pc_i,
  input  wire logic [15:0] chk_status_i,
  input  wire logic        cp_restore_i,
  input  wire logic [15:0] cp_format_word_i,
  output logic      [15:0] cp_format_o,
  output logic             cp_format_valid_o,
  input  wire logic        cp_format_err_i,
  output logic             exc_valid_o,
  output tfe_entry_t       exc_o,
  output logic      [31:0] exc_vec_addr_o,
  input  wire logic        exc_ack_i
);

  logic              rst_s1;
  logic              rst_n;
  tfe_tr_state_t     tr_state;
  tfe_tr_state_t     next_tr_state;
  logic [1:0]        start_mode;
  logic              arm_now;
  logic [31:0]       tr_pc;
  logic [15:0]       tr_sr;
  logic              cp_err_s1;
  logic              cp_err_s2;
  logic              cp_err_s3;
  logic              cp_err_rise;
  logic [31:0]       cp_pc;
  logic [15:0]       cp_sr;
  logic              rte_bad;
  logic              mod_bad;
  logic              fmt_pend;
  logic [31:0]       fmt_pc;
  logic [15:0]       fmt_sr;
  logic              issue_trace;
  logic              issue_fmt;
  logic [31:0]       vbr;
  logic [IRQ_W-1:0]  irq_stat;
  logic [IRQ_W-1:0]  irq_mask;
  logic [IRQ_W-1:0]  irq_set;
  logic [7:0]        last_vec;
  logic              bus_wr;

  function automatic logic [15:0] entry_sr(input logic [15:0] sr);
    logic [15:0] v;
    v            = sr;
    v[SR_S_BIT]  = 1'b1;
    v[SR_T0_BIT] = 1'b0;
    v[SR_T1_BIT] = 1'b0;
    return v;
  endfunction

  // reset release through two flops
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // trace bits read at instruction start; reserved pair treated as off
  assign start_mode = {status_word_i[SR_T1_BIT], status_word_i[SR_T0_BIT]};
  always_comb
  begin
    case (start_mode)
      TMODE_ALL:  arm_now = (instr_class_i != CLS_ILLEGAL);
      TMODE_FLOW: arm_now = (instr_class_i == CLS_FLOW) || (instr_class_i == CLS_STOP);
      default:    arm_now = 1'b0;
    endcase
  end

  always_comb
  begin
    next_tr_state = tr_state;
    case (tr_state)
      TR_IDLE:
      begin
        if (instr_start_i && arm_now)
          next_tr_state = TR_ARMED;
      end
      TR_ARMED, TR_DEFER:
      begin
        if (instr_fault_i)
          next_tr_state = TR_DEFER;
        else if (instr_done_i && forced_exc_i)
          next_tr_state = TR_FORCED;
        else if (instr_done_i)
          next_tr_state = TR_READY;
      end
      TR_FORCED:
      begin
        if (forced_ret_i)
          next_tr_state = TR_READY;
      end
      TR_READY:
      begin
        if (issue_trace)
          next_tr_state = TR_IDLE;
      end
      default: next_tr_state = TR_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      tr_state <= TR_IDLE;
    else
      tr_state <= next_tr_state;
  end

  // the resumed instruction keeps its original trace decision, so no resampling in defer
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tr_pc <= 32'h0;
      tr_sr <= 16'h0;
    end
    else if ((tr_state == TR_ARMED || tr_state == TR_DEFER) && instr_done_i && !instr_fault_i)
    begin
      tr_pc <= next_pc_i;
      tr_sr <= done_status_i;
    end
  end

  // halt in trace-all mode loads status and traces instead of stopping
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      stop_inhibit_o <= 1'b0;
    else if (instr_start_i && tr_state == TR_IDLE)
      stop_inhibit_o <= (instr_class_i == CLS_STOP) && (start_mode == TMODE_ALL);
  end

  // core holds interrupt entry off while a finished trace waits
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      irq_hold_o <= 1'b0;
    else
      irq_hold_o <= (next_tr_state == TR_READY);
  end

  assign rte_bad = rte_check_i && (!FRAME_VALID_MAP[rte_frame_fmt_i]
                   || (rte_frame_fmt_i == FRAME_LONG_BF && rte_frame_ver_i != CPU_VERSION));
  assign mod_bad = mod_check_i && (mod_opt_i != DESC_OPT_OK || mod_type_i != DESC_TYPE_OK
                   || mmu_rights_err_i);

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      ver_addr_o <= 32'h0;
    else
      ver_addr_o <= stack_ptr_i + VERSION_OFS;
  end

  // coprocessor answer is outside logic: synchronise before use
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cp_err_s1 <= 1'b0;
      cp_err_s2 <= 1'b0;
      cp_err_s3 <= 1'b0;
    end
    else
    begin
      cp_err_s1 <= cp_format_err_i;
      cp_err_s2 <= cp_err_s1;
      cp_err_s3 <= cp_err_s2;
    end
  end
  assign cp_err_rise = cp_err_s2 && !cp_err_s3;

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cp_format_o       <= 16'h0;
      cp_format_valid_o <= 1'b0;
      cp_pc             <= 32'h0;
      cp_sr             <= 16'h0;
    end
    else
    begin
      cp_format_valid_o <= cp_restore_i;
      if (cp_restore_i)
      begin
        cp_format_o <= cp_format_word_i;
        cp_pc       <= chk_pc_i;
        cp_sr       <= chk_status_i;
      end
    end
  end

  // one exception slot; a waiting trace beats a format error
  assign issue_trace = !exc_valid_o && tr_state == TR_READY;
  assign issue_fmt   = !exc_valid_o && tr_state != TR_READY && fmt_pend;

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fmt_pend <= 1'b0;
      fmt_pc   <= 32'h0;
      fmt_sr   <= 16'h0;
    end
    else if (rte_bad || mod_bad)
    begin
      fmt_pend <= 1'b1;
      fmt_pc   <= chk_pc_i;
      fmt_sr   <= chk_status_i;
    end
    else if (cp_err_rise)
    begin
      fmt_pend <= 1'b1;
      fmt_pc   <= cp_pc;
      fmt_sr   <= cp_sr;
    end
    else if (issue_fmt)
      fmt_pend <= 1'b0;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      exc_valid_o    <= 1'b0;
      exc_o          <= '0;
      exc_vec_addr_o <= 32'h0;
    end
    else if (issue_trace)
    begin
      exc_valid_o        <= 1'b1;
      exc_o.vector       <= VEC_TRACE;
      exc_o.frame_fmt    <= FRAME_NORMAL;
      exc_o.pc           <= tr_pc;
      exc_o.saved_sr     <= tr_sr;
      exc_o.new_sr       <= entry_sr(tr_sr);
      exc_vec_addr_o     <= vbr + {22'h0, VEC_TRACE, 2'h0};
    end
    else if (issue_fmt)
    begin
      exc_valid_o        <= 1'b1;
      exc_o.vector       <= VEC_FMT_ERR;
      exc_o.frame_fmt    <= FRAME_SHORT_BF;
      exc_o.pc           <= fmt_pc;
      exc_o.saved_sr     <= fmt_sr;
      exc_o.new_sr       <= entry_sr(fmt_sr);
      exc_vec_addr_o     <= vbr + {22'h0, VEC_FMT_ERR, 2'h0};
    end
    else if (exc_ack_i)
      exc_valid_o <= 1'b0;
  end

  // bus slave: every access answers one cycle after it is seen
  assign bus_wr = avs_write_i && !avs_waitrequest_o;

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0;
    end
    else if (!avs_waitrequest_o)
      avs_waitrequest_o <= 1'b1;
    else if (avs_read_i || avs_write_i)
    begin
      avs_waitrequest_o <= 1'b0;
      case (avs_address_i)
        REG_VBR:   avs_readdata_o <= vbr;
        REG_STAT:  avs_readdata_o <= {29'h0, irq_stat};
        REG_MASK:  avs_readdata_o <= {29'h0, irq_mask};
        REG_STATE: avs_readdata_o <= {16'h0, last_vec, 3'h0, fmt_pend, stop_inhibit_o, irq_hold_o,
                                      exc_valid_o, tr_state != TR_IDLE};
        default:   avs_readdata_o <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vbr      <= VBR_RST;
      irq_mask <= '0;
    end
    else if (bus_wr && avs_address_i == REG_VBR)
      vbr <= avs_writedata_i;
    else if (bus_wr && avs_address_i == REG_MASK)
      irq_mask <= avs_writedata_i[IRQ_W-1:0];
  end

  assign irq_set = {cp_err_rise, issue_fmt, issue_trace};

  // write-one clears; a new event in the same cycle keeps its bit
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      irq_stat <= '0;
    else if (bus_wr && avs_address_i == REG_STAT)
      irq_stat <= (irq_stat & ~avs_writedata_i[IRQ_W-1:0]) | irq_set;
    else
      irq_stat <= irq_stat | irq_set;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_o    <= 1'b0;
      last_vec <= 8'h0;
    end
    else
    begin
      irq_o <= |((irq_stat | irq_set) & irq_mask);
      if (issue_trace || issue_fmt)
        last_vec <= issue_trace ? VEC_TRACE : VEC_FMT_ERR;
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n);

  sequence s_idle_start(logic [1:0] m);
    tr_state == TR_IDLE && instr_start_i && start_mode == m;
  endsequence
  sequence s_done_clean;
    (tr_state == TR_ARMED || tr_state == TR_DEFER) && instr_done_i && !instr_fault_i;
  endsequence

  a_off_no_arm: assert property (s_idle_start(TMODE_OFF) or s_idle_start(TMODE_RSVD) |=> tr_state == TR_IDLE)
    else $error("trace armed with tracing off");
  a_flow_skip_seq: assert property (s_idle_start(TMODE_FLOW) ##0 instr_class_i == CLS_SEQ |=> tr_state == TR_IDLE)
    else $error("sequential instruction traced in flow mode");
  a_all_arms: assert property (s_idle_start(TMODE_ALL) ##0 instr_class_i != CLS_ILLEGAL |=> tr_state == TR_ARMED)
    else $error("trace-all did not arm");
  a_illegal_untraced: assert property (tr_state == TR_IDLE && instr_start_i && instr_class_i == CLS_ILLEGAL
    |=> tr_state == TR_IDLE)
    else $error("illegal instruction armed a trace");
  // a trace may only follow a defer once the resumed instruction has reported a clean finish
  a_fault_defers: assert property (tr_state == TR_ARMED && instr_fault_i |=> tr_state == TR_DEFER
    ##1 (!issue_trace || $past(instr_done_i)))
    else $error("trace not deferred by fault");
  a_forced_first: assert property (s_done_clean ##0 forced_exc_i |=> tr_state == TR_FORCED && !irq_hold_o)
    else $error("trace did not wait for forced exception");
  // an entry still waiting for its ack legally delays the trace, so only a free slot is checked
  a_trace_before_irq: assert property (s_done_clean ##0 !forced_exc_i ##1 !exc_valid_o |-> irq_hold_o
    ##1 (exc_valid_o && exc_o.vector == VEC_TRACE))
    else $error("interrupt not held behind trace");
  a_trace_entry: assert property ($rose(exc_valid_o) && exc_o.vector == VEC_TRACE |-> exc_o.pc == tr_pc
    && exc_o.new_sr[SR_S_BIT] && exc_o.new_sr[SR_T1_BIT:SR_T0_BIT] == 2'h0 && exc_o.saved_sr == tr_sr)
    else $error("trace entry state wrong");
  a_stop_traced: assert property (s_idle_start(TMODE_ALL) ##0 instr_class_i == CLS_STOP |=> stop_inhibit_o)
    else $error("traced halt not inhibited");
  a_rte_format: assert property (rte_bad |=> fmt_pend || exc_valid_o)
    else $error("bad frame not flagged");
  a_fmt_frame: assert property ($rose(exc_valid_o) && exc_o.vector == VEC_FMT_ERR |-> exc_o.frame_fmt
    == FRAME_SHORT_BF && exc_vec_addr_o == vbr + 32'h38)
    else $error("format error entry wrong");

endmodule

//--- design/tfe_pkg.sv
/*
  Constants, types and register map for the trace and format-error exception unit.
  Assumes a core that reports instruction start/finish and frame checks on the same clock.
*/
package tfe_pkg;

  localparam int          SR_S_BIT        = 13;
  localparam int          SR_T0_BIT       = 14;
  localparam int          SR_T1_BIT       = 15;
  localparam logic [1:0]  TMODE_OFF       = 2'h0;
  localparam logic [1:0]  TMODE_FLOW      = 2'h1;
  localparam logic [1:0]  TMODE_ALL       = 2'h2;
  localparam logic [1:0]  TMODE_RSVD      = 2'h3;
  localparam logic [7:0]  VEC_TRACE       = 8'h09;
  localparam logic [7:0]  VEC_FMT_ERR     = 8'h0e;
  localparam logic [3:0]  FRAME_NORMAL    = 4'h0;
  localparam logic [3:0]  FRAME_SHORT_BF  = 4'ha;
  localparam logic [3:0]  FRAME_LONG_BF   = 4'hb;
  localparam logic [15:0] FRAME_VALID_MAP = 16'h0e07;
  localparam logic [31:0] VERSION_OFS     = 32'h0000_0036;
  localparam logic [2:0]  DESC_OPT_OK     = 3'h0;
  localparam logic [4:0]  DESC_TYPE_OK    = 5'h00;
  localparam logic [3:0]  REG_VBR         = 4'h0;
  localparam logic [3:0]  REG_STAT        = 4'h4;
  localparam logic [3:0]  REG_MASK        = 4'h8;
  localparam logic [3:0]  REG_STATE       = 4'hc;
  localparam logic [31:0] VBR_RST         = 32'h0000_0000;
  localparam int          IRQ_TRACE       = 0;
  localparam int          IRQ_FMT         = 1;
  localparam int          IRQ_CPFMT       = 2;
  localparam int          IRQ_W           = 3;

  typedef enum logic [1:0] {CLS_SEQ, CLS_FLOW, CLS_STOP, CLS_ILLEGAL} tfe_cls_t;
  typedef enum logic [2:0] {TR_IDLE, TR_ARMED, TR_DEFER, TR_FORCED, TR_READY} tfe_tr_state_t;

  typedef struct packed {
    logic [7:0]  vector;
    logic [3:0]  frame_fmt;
    logic [31:0] pc;
    logic [15:0] saved_sr;
    logic [15:0] new_sr;
  } tfe_entry_t;

endpackage

//--- tb/tfe_cp_model.sv
/*
  Coprocessor stand-in that validates restored state-frame format words.
  Assumes the unit offers each word with a one-cycle valid on ref_clk_i.
*/
`timescale 1ns/1ns
module tfe_cp_model
#(
  parameter logic [15:0] OK_WORD = 16'h0100
)
(
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  input  wire logic [15:0] cp_format_i,
  input  wire logic        cp_format_valid_i,
  input  wire logic [3:0]  lat_i,
  output logic             cp_format_err_o
);
  int cnt;

  // error held three cycles so the unit's synchroniser cannot miss the rise
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cnt             <= 0;
      cp_format_err_o <= 1'b0;
    end
    else if (cp_format_valid_i && cp_format_i != OK_WORD)
      cnt <= lat_i + 5;
    else if (cnt > 0)
    begin
      cnt             <= cnt - 1;
      cp_format_err_o <= (cnt > 1) && (cnt <= 4);
    end
  end
endmodule

//--- tb/trace_and_format_error_exceptions_test.sv
/*
  Self-checking bench for the trace and format-error exception unit.
  Assumes the unit's hand-over timing and a coprocessor model on the restore path.
*/
`timescale 1ns/1ns
module trace_and_format_error_exceptions_test;
  import tfe_pkg::*;
  localparam logic [3:0]  VER   = 4'h5;
  localparam logic [15:0] CP_OK = 16'h0100;
  logic        ref_clk_i, rstn_i, avs_read_i, avs_write_i, avs_waitrequest_o, irq_o, instr_start_i;
  logic        instr_done_i, instr_fault_i, forced_exc_i, forced_ret_i, stop_inhibit_o, irq_hold_o;
  logic        rte_check_i, mod_check_i, mmu_rights_err_i, cp_restore_i, cp_format_valid_o;
  logic        cp_format_err_i, exc_valid_o, exc_ack_i;
  logic [2:0]  mod_opt_i, mask_m;
  logic [4:0]  mod_type_i;
  logic [3:0]  avs_address_i, rte_frame_fmt_i, rte_frame_ver_i, cp_lat;
  logic [15:0] status_word_i, done_status_i, chk_status_i, cp_format_word_i, cp_format_o;
  logic [31:0] avs_writedata_i, avs_readdata_o, next_pc_i, stack_ptr_i, ver_addr_o, chk_pc_i;
  logic [31:0] exc_vec_addr_o, vbr, q;
  tfe_cls_t    instr_class_i;
  tfe_entry_t  exc_o;
  tfe_entry_t  exp_q[$];
  int          sb_q[$];
  int          n_fail, cmp_count;

  tfe_exc_unit #(.CPU_VERSION(VER)) u_dut (.ref_clk_i, .rstn_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .irq_o, .instr_start_i, .instr_class_i,
    .status_word_i, .instr_done_i, .done_status_i, .next_pc_i, .instr_fault_i, .forced_exc_i, .forced_ret_i,
    .stop_inhibit_o, .irq_hold_o, .rte_check_i, .rte_frame_fmt_i, .rte_frame_ver_i, .stack_ptr_i, .ver_addr_o,
    .mod_check_i, .mod_opt_i, .mod_type_i, .mmu_rights_err_i, .chk_pc_i, .chk_status_i, .cp_restore_i,
    .cp_format_word_i, .cp_format_o, .cp_format_valid_o, .cp_format_err_i, .exc_valid_o, .exc_o,
    .exc_vec_addr_o, .exc_ack_i);

  tfe_cp_model #(.OK_WORD(CP_OK)) u_cp (.ref_clk_i, .rstn_i, .cp_format_i(cp_format_o),
    .cp_format_valid_i(cp_format_valid_o), .lat_i(cp_lat), .cp_format_err_o(cp_format_err_i));

  initial
  begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic clk(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  // the slave answers in its own time; a wait ends on waitrequest low or at the bound below
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int t;
    t = 0;
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= wr;
    avs_read_i      <= !wr;
    do
    begin
      clk(1);
      t++;
    end while (avs_waitrequest_o !== 1'b0 && t < 20);
    r = avs_readdata_o;
    chk(t < 20, 1);
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    clk(1);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  task automatic quiet(input int n);
    repeat (n)
    begin
      clk(1);
      chk(exc_valid_o, 1'b0);
    end
  endtask

  task automatic take();
    tfe_entry_t e;
    int         t;
    int         sb;
    t = 0;
    while (exc_valid_o !== 1'b1 && t < 24)
    begin
      clk(1);
      t++;
    end
    e  = exp_q.pop_front();
    sb = sb_q.pop_front();
    chk(exc_valid_o, 1'b1);
    if (e.vector == VEC_TRACE)
      chk(exc_o, e);
    else
      chk(exc_o, e);
    chk(exc_vec_addr_o, 32'(vbr + {22'h0, e.vector, 2'h0}));
    exc_ack_i <= 1'b1;
    clk(1);
    exc_ack_i <= 1'b0;
    clk(2);
    chk(exc_valid_o, 1'b0);
    rd(REG_STAT, sb);
    chk(irq_o, |(sb[2:0] & mask_m));
    bus(1'b1, REG_STAT, 32'h7, q);
    clk(1);
    chk(irq_o, 1'b0);
  endtask

  task automatic run_instr(input logic [1:0] m, input tfe_cls_t c, input int kind);
    tfe_entry_t e;
    logic       tr;
    tr = (m == TMODE_ALL && c != CLS_ILLEGAL) || (m == TMODE_FLOW && (c == CLS_FLOW || c == CLS_STOP));
    status_word_i <= {m, 14'($urandom)};
    instr_class_i <= c;
    instr_start_i <= 1'b1;
    clk(1);
    instr_start_i <= 1'b0;
    clk(1);
    chk(stop_inhibit_o, m == TMODE_ALL && c == CLS_STOP);
    if (kind == 1)
    begin
      instr_fault_i <= 1'b1;
      clk(1);
      instr_fault_i <= 1'b0;
      quiet(6);
    end
    e.vector    = VEC_TRACE;
    e.frame_fmt = FRAME_NORMAL;
    e.pc        = $urandom;
    e.saved_sr  = 16'($urandom);
    e.new_sr    = {2'h0, 1'b1, e.saved_sr[12:0]};
    next_pc_i     <= e.pc;
    done_status_i <= e.saved_sr;
    forced_exc_i  <= (kind == 2);
    instr_done_i  <= 1'b1;
    clk(1);
    instr_done_i <= 1'b0;
    forced_exc_i <= 1'b0;
    if (kind == 2)
    begin
      quiet(6);
      forced_ret_i <= 1'b1;
      clk(1);
      forced_ret_i <= 1'b0;
    end
    else
    begin
      clk(1);
      chk(irq_hold_o, tr);
    end
    if (tr)
    begin
      exp_q.push_back(e);
      sb_q.push_back(1);
      take();
    end
    else
      quiet(8);
  endtask

  // k: 0 frame return check, 1 module check, 2 coprocessor restore
  task automatic fmt(input int k, input logic [15:0] a, input logic [3:0] b);
    tfe_entry_t e;
    logic       bad;
    e           = '0;
    e.vector    = VEC_FMT_ERR;
    e.frame_fmt = FRAME_SHORT_BF;
    e.pc        = $urandom;
    e.saved_sr  = 16'($urandom);
    e.new_sr    = {2'h0, 1'b1, e.saved_sr[12:0]};
    chk_pc_i         <= e.pc;
    chk_status_i     <= e.saved_sr;
    stack_ptr_i      <= $urandom;
    rte_frame_fmt_i  <= a[3:0];
    rte_frame_ver_i  <= b;
    mod_opt_i        <= a[2:0];
    mod_type_i       <= a[7:3];
    mmu_rights_err_i <= b[0];
    cp_format_word_i <= a;
    cp_lat           <= 4'($urandom % 8);
    rte_check_i      <= (k == 0);
    mod_check_i      <= (k == 1);
    cp_restore_i     <= (k == 2);
    if (k == 0)
      bad = !FRAME_VALID_MAP[a[3:0]] || (a[3:0] == FRAME_LONG_BF && b != VER);
    else if (k == 1)
      bad = a[2:0] != DESC_OPT_OK || a[7:3] != DESC_TYPE_OK || b[0];
    else
      bad = a != CP_OK;
    clk(1);
    rte_check_i  <= 1'b0;
    mod_check_i  <= 1'b0;
    cp_restore_i <= 1'b0;
    clk(1);
    chk(ver_addr_o, 32'(stack_ptr_i + VERSION_OFS));
    if (k == 2)
      chk({cp_format_valid_o, cp_format_o}, {1'b1, a});
    if (bad)
    begin
      exp_q.push_back(e);
      sb_q.push_back(k == 2 ? 6 : 2);
      take();
    end
    else
      quiet(20);
  endtask

  initial
  begin
    {avs_read_i, avs_write_i, instr_start_i, instr_done_i, instr_fault_i, forced_exc_i, forced_ret_i} = '0;
    {rte_check_i, mod_check_i, mmu_rights_err_i, cp_restore_i, exc_ack_i, mod_opt_i, mod_type_i} = '0;
    {avs_address_i, rte_frame_fmt_i, rte_frame_ver_i, cp_lat, status_word_i, done_status_i} = '0;
    {chk_status_i, cp_format_word_i, avs_writedata_i, next_pc_i, stack_ptr_i, chk_pc_i} = '0;
    instr_class_i = CLS_SEQ;
    mask_m        = 3'h7;
    rstn_i        = 1'b0;
    void'($urandom(88));
    clk(16);
    rstn_i <= 1'b1;
    clk(3);
    rd(REG_VBR, VBR_RST);
    rd(REG_MASK, 32'h0);
    rd(REG_STAT, 32'h0);
    rd(4'h2, 32'h0);
    bus(1'b1, REG_STATE, 32'hffff_ffff, q);
    rd(REG_STATE, 32'h0);
    vbr = $urandom;
    bus(1'b1, REG_VBR, vbr, q);
    rd(REG_VBR, vbr);
    bus(1'b1, REG_MASK, 32'h7, q);
    rd(REG_MASK, 32'h7);
    for (int m = 0; m < 4; m++)
      for (int c = 0; c < 4; c++)
        run_instr(2'(m), tfe_cls_t'(c), 0);
    run_instr(TMODE_ALL, CLS_SEQ, 1);
    run_instr(TMODE_FLOW, CLS_FLOW, 2);
    mask_m = 3'h6;
    bus(1'b1, REG_MASK, 32'h6, q);
    run_instr(TMODE_ALL, CLS_STOP, 0);
    mask_m = 3'h7;
    bus(1'b1, REG_MASK, 32'h7, q);
    repeat (8)
      run_instr(2'($urandom), tfe_cls_t'($urandom % 4), $urandom % 3);
    for (int f = 0; f < 16; f++)
      fmt(0, 16'(f), VER);
    fmt(0, 16'(FRAME_LONG_BF), VER + 4'h1);
    fmt(1, 16'h0000, 4'h0);
    fmt(1, 16'h0001, 4'h0);
    fmt(1, 16'h0008, 4'h0);
    fmt(1, 16'h0000, 4'h1);
    fmt(2, CP_OK, 4'h0);
    repeat (3)
      fmt(2, 16'($urandom), 4'h0);
    complete_run();
  end

  initial
  begin
    clk(20000);
    n_fail++;
    complete_run();
  end
endmodule
